// ===== rtl/srw_pkg.sv
package srw_pkg;
    // Core clock rate
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    // Reset hold interval, nominal 200 ms
    localparam int unsigned HOLD_MS = 200;
    // Watchdog timeout, nominal 1.6 s, kept in ms
    localparam int unsigned WDOG_MS = 1600;
    // Pushbutton glitch immunity, 100 ns
    localparam int unsigned PB_GLITCH_NS = 100;
    // Supply glitch reject width, 30 ns
    localparam int unsigned UV_GLITCH_NS = 30;
    // Internal timebase tick, 1 ms
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    // Filters reject pulses no longer than the glitch width: round up
    localparam int unsigned PB_FILT_CYCLES = (PB_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UV_FILT_CYCLES = (UV_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Tick counts of hold and watchdog intervals
    localparam int unsigned HOLD_TICKS = HOLD_MS * 1000 / TICK_US;
    localparam int unsigned WDOG_TICKS = WDOG_MS * 1000 / TICK_US;
    // Watchdog source select values
    localparam logic WDOG_SRC_BUS = 1'h0;
    localparam logic WDOG_SRC_KICK = 1'h1;

    typedef enum logic [1:0] {
        SRW_ASSERT,
        SRW_HOLD,
        SRW_RUN
    } srw_state_t;
endpackage : srw_pkg

// ===== rtl/srw_supervisor.sv
`timescale 1ns/1ps
module srw_supervisor #(
    parameter int unsigned TICK_CYCLES = srw_pkg::TICK_CYCLES,
    parameter int unsigned HOLD_TICKS = srw_pkg::HOLD_TICKS,
    parameter int unsigned WDOG_TICKS = srw_pkg::WDOG_TICKS,
    parameter logic WDOG_SRC = srw_pkg::WDOG_SRC_KICK,
    parameter logic HAS_WP = 1'h1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic supply_low,
    input wire logic pushbutton_reset_in_n,
    input wire logic reset_pin_in_n,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic reset_hi_out,
    output logic reset_hi_oe_n,
    input wire logic watchdog_kick_in,
    input wire logic bus_data_in,
    input wire logic write_protect_in,
    input wire logic mem_busy,
    input wire logic nv_write_req,
    input wire logic nv_write_busy,
    output logic mem_enable,
    output logic mem_abort,
    output logic nv_write_start,
    output logic nv_write_allow
);
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
    localparam int unsigned HW = $clog2(HOLD_TICKS + 1);
    localparam int unsigned WW = $clog2(WDOG_TICKS + 1);
    localparam int unsigned PW = $clog2(srw_pkg::PB_FILT_CYCLES + 2);
    localparam int unsigned UW = $clog2(srw_pkg::UV_FILT_CYCLES + 2);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_TICKS);
    localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_TICKS);
    localparam logic [PW-1:0] PB_LIM = PW'(srw_pkg::PB_FILT_CYCLES + 1);
    localparam logic [UW-1:0] UV_LIM = UW'(srw_pkg::UV_FILT_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Input filters and edge detection
    logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic [PW-1:0] pb_cnt_reg, pb_cnt_next;
    logic pb_low_reg, pb_low_next;
    logic [UW-1:0] uv_cnt_reg, uv_cnt_next;
    logic uv_reg, uv_next;
    logic pin_prev_reg, pin_prev_next;
    logic wd_prev_reg, wd_prev_next;
    logic wd_line;
    logic pin_fall;
    logic wd_edge;

    assign wd_line = (WDOG_SRC == srw_pkg::WDOG_SRC_KICK) ? watchdog_kick_in : bus_data_in;
    assign pin_fall = pin_prev_reg && !reset_pin_in_n;
    assign wd_edge = wd_prev_reg != wd_line;

    always_comb begin
        tick_cnt_next = tick_cnt_reg + TW'(1);
        tick_next = 1'h0;
        if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_next = '0;
            tick_next = 1'h1;
        end
        // Low must outlast the glitch width before it counts
        pb_cnt_next = '0;
        pb_low_next = 1'h0;
        if (!pushbutton_reset_in_n) begin
            pb_cnt_next = (pb_cnt_reg == PB_LIM) ? pb_cnt_reg : pb_cnt_reg + PW'(1);
            pb_low_next = pb_low_reg || (pb_cnt_reg == PB_LIM);
        end
        // Assert is filtered, release is immediate so the hold restarts at once
        uv_cnt_next = '0;
        uv_next = 1'h0;
        if (supply_low) begin
            uv_cnt_next = (uv_cnt_reg == UV_LIM) ? uv_cnt_reg : uv_cnt_reg + UW'(1);
            uv_next = uv_reg || (uv_cnt_reg == UV_LIM);
        end
        pin_prev_next = reset_pin_in_n;
        wd_prev_next = wd_line;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'h0;
            pb_cnt_reg <= '0;
            pb_low_reg <= 1'h0;
            uv_cnt_reg <= '0;
            uv_reg <= 1'h1;
            pin_prev_reg <= 1'h1;
            wd_prev_reg <= 1'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            pb_cnt_reg <= pb_cnt_next;
            pb_low_reg <= pb_low_next;
            uv_cnt_reg <= uv_cnt_next;
            uv_reg <= uv_next;
            pin_prev_reg <= pin_prev_next;
            wd_prev_reg <= wd_prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset state, hold timer and watchdog
    srw_pkg::srw_state_t state_reg, state_next;
    logic [HW-1:0] hold_cnt_reg, hold_cnt_next;
    logic [WW-1:0] wd_cnt_reg, wd_cnt_next;
    logic wd_fire;
    logic level_src;
    logic in_reset;

    // Own drive of the pin is excluded: only an edge from outside restarts
    assign level_src = uv_reg || pb_low_reg;
    assign wd_fire = (state_reg == srw_pkg::SRW_RUN) && (wd_cnt_reg == WDOG_LAST);
    assign in_reset = state_next != srw_pkg::SRW_RUN;

    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        wd_cnt_next = wd_cnt_reg;
        unique case (state_reg)
            srw_pkg::SRW_ASSERT: begin
                hold_cnt_next = '0;
                if (!level_src) begin
                    state_next = srw_pkg::SRW_HOLD;
                end
            end
            srw_pkg::SRW_HOLD: begin
                if (level_src) begin
                    state_next = srw_pkg::SRW_ASSERT;
                end else if (pin_fall && reset_pin_oe_n) begin
                    hold_cnt_next = '0;
                end else if (hold_cnt_reg == HOLD_LAST) begin
                    state_next = srw_pkg::SRW_RUN;
                end else if (tick_reg) begin
                    hold_cnt_next = hold_cnt_reg + HW'(1);
                end
            end
            srw_pkg::SRW_RUN: begin
                if (level_src) begin
                    state_next = srw_pkg::SRW_ASSERT;
                end else if (pin_fall || wd_fire) begin
                    state_next = srw_pkg::SRW_HOLD;
                    hold_cnt_next = '0;
                end
            end
        endcase
        if (state_next != srw_pkg::SRW_RUN || wd_edge) begin
            wd_cnt_next = '0;
        end else if (tick_reg && wd_cnt_reg != WDOG_LAST) begin
            wd_cnt_next = wd_cnt_reg + WW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    logic rst_out_reg;
    logic mem_en_reg, mem_abort_reg, wr_start_reg, wr_allow_reg;
    logic rst_out_next;
    logic mem_en_next, mem_abort_next, wr_start_next, wr_allow_next;

    always_comb begin
        rst_out_next = in_reset;
        mem_en_next = !in_reset;
        mem_abort_next = in_reset && mem_busy;
        // Writes are blocked when protected; a running write is never touched
        wr_allow_next = !in_reset && !(HAS_WP && write_protect_in);
        wr_start_next = wr_allow_next && nv_write_req && !nv_write_busy;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= srw_pkg::SRW_ASSERT;
            hold_cnt_reg <= '0;
            wd_cnt_reg <= '0;
            rst_out_reg <= 1'h1;
            mem_en_reg <= 1'h0;
            mem_abort_reg <= 1'h0;
            wr_start_reg <= 1'h0;
            wr_allow_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            wd_cnt_reg <= wd_cnt_next;
            rst_out_reg <= rst_out_next;
            mem_en_reg <= mem_en_next;
            mem_abort_reg <= mem_abort_next;
            wr_start_reg <= wr_start_next;
            wr_allow_reg <= wr_allow_next;
        end
    end

    // Open drain: drive low level / high level only while asserted
    assign reset_pin_out = 1'h0;
    assign reset_pin_oe_n = !rst_out_reg;
    assign reset_hi_out = 1'h1;
    assign reset_hi_oe_n = !rst_out_reg;
    assign mem_enable = mem_en_reg;
    assign mem_abort = mem_abort_reg;
    assign nv_write_start = wr_start_reg;
    assign nv_write_allow = wr_allow_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_hold_done;
        state_reg == srw_pkg::SRW_HOLD && hold_cnt_reg == HOLD_LAST && !level_src
            && !(pin_fall && reset_pin_oe_n);
    endsequence

    a_release_after_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_hold_done |=> state_reg == srw_pkg::SRW_RUN ##1 !reset_pin_oe_n == 1'h0)
        else $error("reset not released after hold");
    a_uv_asserts: assert property (@(posedge core_clk) disable iff (!arst_n)
        uv_reg |-> ##[1:2] !reset_pin_oe_n)
        else $error("undervoltage did not assert reset");
    a_uv_glitch: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(supply_low) ##1 !supply_low |-> ##1 !uv_reg)
        else $error("supply glitch reached reset");
    a_pin_restarts: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_reg == srw_pkg::SRW_RUN && !level_src && pin_fall
            |=> state_reg == srw_pkg::SRW_HOLD && hold_cnt_reg == '0)
        else $error("pin fall did not start hold");
    a_pb_glitch: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(pushbutton_reset_in_n) ##1 pushbutton_reset_in_n |-> ##1 !pb_low_reg)
        else $error("pushbutton glitch accepted");
    a_pb_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
        pb_low_reg |=> state_reg == srw_pkg::SRW_ASSERT)
        else $error("pushbutton low not holding reset");
    a_mem_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        !reset_pin_oe_n |-> !mem_enable && !nv_write_allow)
        else $error("memory enabled during reset");
    a_wp_blocks: assert property (@(posedge core_clk) disable iff (!arst_n)
        HAS_WP && $past(write_protect_in) |-> !nv_write_start)
        else $error("write started while protected");
    a_wd_cleared: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_reg != srw_pkg::SRW_RUN |-> wd_cnt_reg == '0)
        else $error("watchdog counted during reset");
    a_wd_fires: assert property (@(posedge core_clk) disable iff (!arst_n)
        wd_fire && !level_src |=> state_reg == srw_pkg::SRW_HOLD ##1 !reset_pin_oe_n)
        else $error("watchdog timeout missed");
    a_outs_match: assert property (@(posedge core_clk) disable iff (!arst_n)
        reset_pin_oe_n == reset_hi_oe_n)
        else $error("reset outputs disagree");

    // Filters: an accepted level must have stood for the full filter length
    a_uv_filter_len: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(uv_reg) |-> $past(supply_low, srw_pkg::UV_FILT_CYCLES + 2))
        else $error("undervoltage accepted too early");
    a_pb_filter_len: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(pb_low_reg) |-> !$past(pushbutton_reset_in_n, srw_pkg::PB_FILT_CYCLES + 2))
        else $error("pushbutton accepted too early");

    // State walk: the hold interval ends by running out or by a level source sending it back to assert
    a_assert_to_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_reg == srw_pkg::SRW_ASSERT && !level_src |=> state_reg == srw_pkg::SRW_HOLD)
        else $error("hold not entered after source ended");
    a_hold_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_reg == srw_pkg::SRW_HOLD && level_src |=> state_reg == srw_pkg::SRW_ASSERT)
        else $error("hold not restarted by source");
    a_hold_no_early: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_reg == srw_pkg::SRW_HOLD && !level_src && hold_cnt_reg != HOLD_LAST
            |=> state_reg == srw_pkg::SRW_HOLD)
        else $error("hold ended early");

    // Watchdog counter steps only on a tick and clears on any line edge
    a_wd_kick_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        wd_edge |=> wd_cnt_reg == '0)
        else $error("line edge did not clear watchdog");
    a_wd_step: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_reg == srw_pkg::SRW_RUN && !level_src && !pin_fall && !wd_fire && !wd_edge
            && !tick_reg |=> $stable(wd_cnt_reg))
        else $error("watchdog moved without a tick");

    // Memory gating follows the registered reset state
    a_mem_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        reset_pin_oe_n |-> mem_enable && !mem_abort)
        else $error("memory blocked out of reset");
    a_abort_on_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(arst_n) && $past(mem_busy) && !reset_pin_oe_n |-> mem_abort)
        else $error("transaction not aborted in reset");
    a_start_busy: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(arst_n) && $past(nv_write_busy) |-> !nv_write_start)
        else $error("write started over a running one");
    a_start_taken: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(arst_n) && $past(nv_write_req && !nv_write_busy) && nv_write_allow
            |-> nv_write_start)
        else $error("allowed write not started");
endmodule : srw_supervisor

// ===== tb/srw_mcu_model.sv
`timescale 1ns/1ps
module srw_mcu_model #(
    parameter int unsigned KICK_GAP = 8
) (
    input wire logic core_clk,
    input wire logic reset_pin_oe_n,
    input wire logic kick_en,
    input wire logic pull_req,
    output logic reset_pin_in_n,
    output logic watchdog_kick_in
);
    int unsigned gap_cnt = 0;
    logic kick_reg = 1'h0;
    // Wire level: low while either side pulls, otherwise the pull-up wins
    assign reset_pin_in_n = reset_pin_oe_n & ~pull_req;
    assign watchdog_kick_in = kick_reg;
    // Firmware only runs out of reset, so a long reset also stops the kicks
    always @(posedge core_clk) begin
        gap_cnt <= (gap_cnt + 1) % KICK_GAP;
        if (kick_en && reset_pin_in_n && gap_cnt == 0) begin
            kick_reg <= ~kick_reg;
        end
    end
endmodule : srw_mcu_model

// ===== tb/supervisor_reset_watchdog_tb.sv
`timescale 1ns/1ps
module supervisor_reset_watchdog_tb;
    localparam int TCK = 10;
    localparam int HT = 5;
    localparam int WT = 20;
    localparam int LO = (HT - 1) * TCK;
    localparam int HI = HT * TCK + TCK + 25;
    logic core_clk = 1'h0;
    logic arst_n = 1'h0;
    logic supply_low = 1'h1;
    logic pb_n = 1'h1;
    logic bus_data_in = 1'h0;
    logic wp = 1'h0;
    logic mem_busy = 1'h0;
    logic nv_req = 1'h0;
    logic nv_busy = 1'h0;
    logic kick_en = 1'h0;
    logic pull_req = 1'h0;
    logic pin_n, kick, pin_out, pin_oe_n, hi_out, hi_oe_n, mem_en, abort_o, start_o, allow_o;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int mlo, mhi;
    int exp_lo[$];
    int exp_hi[$];
    logic [31:0] seed = 32'h7be094ae;

    srw_supervisor #(.TICK_CYCLES(TCK), .HOLD_TICKS(HT), .WDOG_TICKS(WT)) srw_supervisor_inst (
        .core_clk(core_clk), .arst_n(arst_n), .supply_low(supply_low),
        .pushbutton_reset_in_n(pb_n), .reset_pin_in_n(pin_n), .reset_pin_out(pin_out),
        .reset_pin_oe_n(pin_oe_n), .reset_hi_out(hi_out), .reset_hi_oe_n(hi_oe_n),
        .watchdog_kick_in(kick), .bus_data_in(bus_data_in), .write_protect_in(wp),
        .mem_busy(mem_busy), .nv_write_req(nv_req), .nv_write_busy(nv_busy),
        .mem_enable(mem_en), .mem_abort(abort_o), .nv_write_start(start_o),
        .nv_write_allow(allow_o)
    );
    srw_mcu_model srw_mcu_model_inst (
        .core_clk(core_clk), .reset_pin_oe_n(pin_oe_n), .kick_en(kick_en),
        .pull_req(pull_req), .reset_pin_in_n(pin_n), .watchdog_kick_in(kick)
    );

    always #2.5 core_clk = ~core_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // Release window is noted against the cycle where the source ends
    task automatic expect_rel();
        exp_lo.push_back(cyc + LO);
        exp_hi.push_back(cyc + HI);
    endtask : expect_rel

    task automatic wait_oe(input logic v, input int lim);
        int n = 0;
        while (pin_oe_n !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_oe

    task automatic hold_chk(input logic v, input int n, input string msg);
        bit ok = 1'b1;
        repeat (n) begin
            tick(1);
            if (pin_oe_n !== v) ok = 1'b0;
        end
        chk(ok, msg);
    endtask : hold_chk

    ////////////////////////////////////////////////////////////////
    // Data line noise must never feed the watchdog in the kick build
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        seed <= lfsr(seed);
        bus_data_in <= seed[0];
        if (cyc == 5000) begin
            chk(1'b0, "timeout");
            wrap_up();
        end
    end

    always @(posedge core_clk) begin
        if (arst_n) begin
            chk(hi_oe_n === pin_oe_n && pin_out === 1'h0 && hi_out === 1'h1, "pair");
            if ($rose(pin_oe_n)) begin
                if (exp_lo.size() == 0) begin
                    chk(1'b0, "release not expected");
                end else begin
                    mlo = exp_lo.pop_front();
                    mhi = exp_hi.pop_front();
                    chk(cyc >= mlo && cyc <= mhi, "release out of window");
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        tick(20);
        arst_n <= 1'h1;
        kick_en <= 1'h1;
        mem_busy <= 1'h1;
        nv_req <= 1'h1;
        tick(20);
        chk(pin_oe_n === 1'h0 && mem_en === 1'h0 && allow_o === 1'h0, "reset state");
        chk(abort_o === 1'h1 && start_o === 1'h0, "memory not blocked");
        supply_low <= 1'h0;
        expect_rel();
        wait_oe(1'h1, HI + 5);
        tick(3);
        chk(mem_en === 1'h1 && abort_o === 1'h0, "memory after release");
        repeat (8) begin
            wp <= seed[1];
            tick(3);
            chk(allow_o === ~wp, "write protect");
        end
        wp <= 1'h0;
        tick(3);
        chk(start_o === 1'h1, "write not started");
        nv_busy <= 1'h1;
        tick(3);
        chk(start_o === 1'h0, "write started while busy");
        nv_busy <= 1'h0;
        mem_busy <= 1'h0;
        nv_req <= 1'h0;
        $display("test power_up done");
        supply_low <= 1'h1;
        tick(6);
        supply_low <= 1'h0;
        hold_chk(1'h1, 20, "supply glitch reset");
        supply_low <= 1'h1;
        wait_oe(1'h0, 15);
        chk(pin_oe_n === 1'h0, "no reset on low supply");
        tick(30);
        supply_low <= 1'h0;
        expect_rel();
        wait_oe(1'h1, HI + 5);
        $display("test brownout done");
        pb_n <= 1'h0;
        tick(20);
        pb_n <= 1'h1;
        hold_chk(1'h1, 30, "button glitch reset");
        pb_n <= 1'h0;
        tick(30);
        hold_chk(1'h0, 100, "reset dropped while button low");
        pb_n <= 1'h1;
        expect_rel();
        wait_oe(1'h1, HI + 5);
        $display("test pushbutton done");
        tick(5);
        pull_req <= 1'h1;
        expect_rel();
        tick(5);
        pull_req <= 1'h0;
        wait_oe(1'h1, HI + 5);
        $display("test pin_edge done");
        hold_chk(1'h1, 400, "reset despite kicks");
        kick_en <= 1'h0;
        pb_n <= 1'h0;
        tick(300);
        pb_n <= 1'h1;
        expect_rel();
        wait_oe(1'h1, HI + 5);
        hold_chk(1'h1, (WT - 2) * TCK, "watchdog ran in reset");
        wait_oe(1'h0, 3 * TCK);
        chk(pin_oe_n === 1'h0, "no watchdog reset");
        expect_rel();
        kick_en <= 1'h1;
        wait_oe(1'h1, HI + 5);
        tick(5);
        chk(exp_lo.size() == 0, "release missing");
        $display("test watchdog done");
        wrap_up();
    end
endmodule : supervisor_reset_watchdog_tb
